// ==== hw/seec_params.svh ====
/*
  Timing and field constants for the serial word memory command engine.
  Assumes a 40 MHz system clock; included by the engine, not by its buffer.
*/
`ifndef SEEC_PARAMS_SVH
`define SEEC_PARAMS_SVH

`define SEEC_CLK_NS 25
`define SEEC_PROG_NS 10000000
`define SEEC_PROG_CYC ((`SEEC_PROG_NS) / (`SEEC_CLK_NS))
`define SEEC_ADDR_W 6
`define SEEC_DATA_W 16
`define SEEC_GUARD_W 9
`define SEEC_HDR_BITS 9
`define SEEC_OP_RD 2'h2
`define SEEC_OP_WR 2'h1
`define SEEC_OP_PG 2'h3
`define SEEC_OP_EXT 2'h0
`define SEEC_PFX_FILL 2'h1
`define SEEC_PFX_UNLK 2'h3
`define SEEC_PFX_LOCK 2'h0
`define SEEC_ADDR_ONES 6'h3f
`define SEEC_ADDR_ZERO 6'h00
`define SEEC_PAGE_WORDS 3'h4
`define SEEC_ERASED 16'hffff

`endif

// ==== hw/seec_pkg.sv ====
/*
  Types for the serial word memory command engine.
  Assumes nothing beyond the params header.
*/
package seec_pkg;
  typedef enum logic [3:0] {
    SEEC_IDLE, SEEC_HDR, SEEC_RDOUT, SEEC_GRDOUT, SEEC_DATA,
    SEEC_WAITEND, SEEC_PROG, SEEC_SKIP
  } seec_state_t;
  typedef enum logic [3:0] {
    SEEC_C_NONE, SEEC_C_READ, SEEC_C_WRITE, SEEC_C_PAGE, SEEC_C_FILL,
    SEEC_C_PUNLK, SEEC_C_PLOCK, SEEC_C_GREAD, SEEC_C_GSET, SEEC_C_GRST,
    SEEC_C_GUNLK, SEEC_C_GFRZ
  } seec_cmd_t;
endpackage

// ==== hw/seec_buf2.sv ====
/*
  Two-entry valid/ready buffer for data words on their way to the array.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seec_buf2 #(
  parameter int WIDTH = 22
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic in_valid_i, // Word offered
  output logic in_ready_o, // Room for a word
  input wire logic [WIDTH-1:0] in_data_i, // Word in
  output logic out_valid_o, // Word held
  input wire logic out_ready_i, // Drain side takes it
  output logic [WIDTH-1:0] out_data_o // Oldest word
);
  logic [WIDTH-1:0] mem [0:1];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign push = in_valid_i && (count != 2'h2);
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ==== hw/seec_engine.sv ====
/*
  Instruction decoder and sequencer of a 64 x 16 serial word memory with a
  write guard. Pins arrive from another domain and are synchronised to mclk_i.
  Assumes a host that follows the serial framing described below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seec_params.svh"
module seec_engine
  import seec_pkg::*;
#(
  parameter int PROG_CYCLES = `SEEC_PROG_CYC,
  parameter int DEPTH = 64
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_i, // Sync reset, power-on
  input wire logic sel_i, // Chip select pin
  input wire logic sclk_i, // Serial clock pin
  input wire logic sdi_i, // Serial data in pin
  input wire logic wperm_i, // Write permission pin
  input wire logic gacc_i, // Guard access pin
  output logic sdo_o, // Serial data out
  output logic sdo_oe_n_o, // Low while sdo_o driven
  output logic busy_o, // Programming in progress
  output logic prog_en_o, // Programming unlocked
  output logic frozen_o // Guard boundary frozen
);
  logic [2:0] sel_s;
  logic [2:0] clk_s;
  logic [1:0] sdi_s;
  logic [1:0] wp_s;
  logic [1:0] ga_s;
  logic rise;
  logic sel_fall;
  logic sel_rise;

  logic [`SEEC_DATA_W-1:0] mem [0:DEPTH-1];
  seec_state_t state;
  seec_cmd_t cmd;
  logic [3:0] hcnt;
  logic [8:0] hdr;
  logic [4:0] bcnt;
  logic [`SEEC_DATA_W-1:0] sh;
  logic [`SEEC_ADDR_W-1:0] addr;
  logic [2:0] words;
  logic wp_ok;
  logic [`SEEC_ADDR_W-1:0] guard_addr;
  logic guard_flag;
  logic frozen;
  logic gunlk;
  logic prog_en;
  logic [31:0] pcnt;
  logic fill_busy;
  logic [`SEEC_ADDR_W-1:0] fill_addr;
  logic [`SEEC_DATA_W-1:0] fill_data;
  logic ready_hold;
  logic rdy_pend;
  logic guard_hit;

  logic bin_valid;
  logic bin_ready;
  logic [21:0] bin_data;
  logic bout_valid;
  logic bout_ready;
  logic [21:0] bout_data;
  logic [21:0] page [0:3];
  logic [2:0] pg_n;
  logic [2:0] pg_i;

  seec_cmd_t next_cmd;
  logic [`SEEC_ADDR_W-1:0] a6;
  logic [1:0] op;

  // Two-stage synchronisers; edge detect only on stage two and later
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sel_s <= 3'h0;
      clk_s <= 3'h0;
      sdi_s <= 2'h0;
      wp_s <= 2'h0;
      ga_s <= 2'h0;
    end else begin
      sel_s <= {sel_s[1:0], sel_i};
      clk_s <= {clk_s[1:0], sclk_i};
      sdi_s <= {sdi_s[0], sdi_i};
      wp_s <= {wp_s[0], wperm_i};
      ga_s <= {ga_s[0], gacc_i};
    end
  end
  assign rise = clk_s[1] && !clk_s[2] && sel_s[1];
  assign sel_fall = !sel_s[1] && sel_s[2];
  assign sel_rise = sel_s[1] && !sel_s[2];

  assign op = hdr[6:5];
  assign a6 = {hdr[4:0], sdi_s[1]};

  // Opcode decode after the sixth address bit
  always_comb begin
    next_cmd = SEEC_C_NONE;
    if (!ga_s[1]) begin
      unique case (op)
        `SEEC_OP_RD: next_cmd = SEEC_C_READ;
        `SEEC_OP_WR: next_cmd = SEEC_C_WRITE;
        `SEEC_OP_PG: next_cmd = SEEC_C_PAGE;
        `SEEC_OP_EXT: begin
          if (a6[5:4] == `SEEC_PFX_FILL) begin
            next_cmd = SEEC_C_FILL;
          end else if (a6[5:4] == `SEEC_PFX_UNLK) begin
            next_cmd = SEEC_C_PUNLK;
          end else if (a6[5:4] == `SEEC_PFX_LOCK) begin
            next_cmd = SEEC_C_PLOCK;
          end
        end
      endcase
    end else begin
      unique case (op)
        `SEEC_OP_RD: next_cmd = SEEC_C_GREAD;
        `SEEC_OP_WR: next_cmd = SEEC_C_GSET;
        `SEEC_OP_PG: begin
          if (a6 == `SEEC_ADDR_ONES) begin
            next_cmd = SEEC_C_GRST;
          end
        end
        `SEEC_OP_EXT: begin
          if (a6[5:4] == `SEEC_PFX_UNLK) begin
            next_cmd = SEEC_C_GUNLK;
          end else if (a6 == `SEEC_ADDR_ZERO) begin
            next_cmd = SEEC_C_GFRZ;
          end
        end
      endcase
    end
  end

  // Write and page data words queue through the buffer into the page store; fill data does not
  assign bin_data = {addr, sh[`SEEC_DATA_W-2:0], sdi_s[1]};
  assign bin_valid = (state == SEEC_DATA) && rise && (bcnt == 5'h0f)
    && (cmd != SEEC_C_FILL);
  assign bout_ready = (pg_n < `SEEC_PAGE_WORDS);

  seec_buf2 #(
    .WIDTH(22)
  ) u_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(bin_valid),
    .in_ready_o(bin_ready),
    .in_data_i(bin_data),
    .out_valid_o(bout_valid),
    .out_ready_i(bout_ready),
    .out_data_o(bout_data)
  );

  // Main sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= SEEC_IDLE;
      cmd <= SEEC_C_NONE;
      hcnt <= 4'h0;
      hdr <= 9'h000;
      bcnt <= 5'h00;
      sh <= 16'h0000;
      addr <= 6'h00;
      words <= 3'h0;
      wp_ok <= 1'b0;
      pcnt <= 32'h0;
      pg_i <= 3'h0;
      fill_busy <= 1'b0;
      fill_addr <= 6'h00;
      fill_data <= 16'h0000;
      rdy_pend <= 1'b0;
    end else begin
      // Clear first so that a ready set in the same cycle wins
      if (sel_fall) begin
        rdy_pend <= 1'b0;
      end
      unique case (state)
        SEEC_IDLE: begin
          if (rise && sdi_s[1]) begin
            state <= SEEC_HDR;
            rdy_pend <= 1'b0;
            hcnt <= 4'h1;
            hdr <= 9'h001;
            wp_ok <= wp_s[1];
          end
        end
        SEEC_HDR: begin
          if (!sel_s[1]) begin
            state <= SEEC_IDLE;
          end else if (rise) begin
            hdr <= {hdr[7:0], sdi_s[1]};
            hcnt <= hcnt + 4'h1;
            wp_ok <= wp_ok && wp_s[1];
            if (hcnt == 4'(`SEEC_HDR_BITS - 1)) begin
              cmd <= next_cmd;
              addr <= a6;
              bcnt <= 5'h00;
              words <= 3'h0;
              sh <= mem[a6];
              if (next_cmd == SEEC_C_READ) begin
                state <= SEEC_RDOUT;
              end else if (next_cmd == SEEC_C_GREAD) begin
                state <= SEEC_GRDOUT;
                sh <= {guard_addr, guard_flag, 9'h000};
              end else if (next_cmd == SEEC_C_WRITE
                  || next_cmd == SEEC_C_PAGE
                  || next_cmd == SEEC_C_FILL) begin
                state <= SEEC_DATA;
              end else begin
                state <= SEEC_WAITEND;
              end
            end
          end
        end
        SEEC_RDOUT, SEEC_GRDOUT: begin
          if (!sel_s[1]) begin
            state <= SEEC_IDLE;
          end else if (rise) begin
            bcnt <= bcnt + 5'h01;
            if (bcnt != 5'h00) begin
              sh <= {sh[`SEEC_DATA_W-2:0], 1'b0};
            end
            if (state == SEEC_RDOUT && bcnt == 5'h10) begin
              addr <= addr + 6'h01;
              sh <= mem[addr + 6'h01];
              bcnt <= 5'h01;
            end
          end
        end
        SEEC_DATA: begin
          if (!sel_s[1]) begin
            state <= SEEC_WAITEND;
          end else if (rise) begin
            wp_ok <= wp_ok && wp_s[1];
            sh <= {sh[`SEEC_DATA_W-2:0], sdi_s[1]};
            bcnt <= (bcnt == 5'h0f) ? 5'h00 : bcnt + 5'h01;
            if (bcnt == 5'h0f) begin
              words <= words + 3'h1;
              if (cmd == SEEC_C_FILL) begin
                fill_data <= {sh[`SEEC_DATA_W-2:0], sdi_s[1]};
              end
              // Page address advances inside its group
              addr <= {addr[5:2], addr[1:0] + 2'h1};
              if (cmd != SEEC_C_PAGE || words == 3'h3) begin
                state <= SEEC_WAITEND;
              end
            end
          end
        end
        SEEC_WAITEND: begin
          if (!sel_s[1]) begin
            state <= SEEC_IDLE;
            if (bout_valid) begin
              state <= SEEC_SKIP;
            end else if (words != 3'h0 && wp_ok && prog_en) begin
              if (cmd == SEEC_C_FILL) begin
                if (guard_flag) begin
                  fill_busy <= 1'b1;
                  fill_addr <= 6'h00;
                  state <= SEEC_PROG;
                  pcnt <= 32'h0;
                end
              end else if (cmd == SEEC_C_WRITE || cmd == SEEC_C_PAGE) begin
                state <= SEEC_SKIP;
              end
            end
          end else if (rise && cmd != SEEC_C_PAGE && cmd != SEEC_C_FILL
              && cmd != SEEC_C_WRITE) begin
            state <= SEEC_WAITEND;
          end
        end
        SEEC_SKIP: begin
          // Wait for buffered words to reach the page store, then check
          if (!bout_valid) begin
            state <= SEEC_IDLE;
            if (pg_n != 3'h0 && wp_ok && prog_en) begin
              state <= SEEC_PROG;
              pcnt <= 32'h0;
              pg_i <= 3'h0;
            end
          end
        end
        SEEC_PROG: begin
          if (fill_busy) begin
            mem[fill_addr] <= fill_data;
            fill_addr <= fill_addr + 6'h01;
            if (fill_addr == `SEEC_ADDR_ONES) begin
              fill_busy <= 1'b0;
            end
          end else if (pg_i < pg_n) begin
            if (!guard_hit) begin
              mem[page[pg_i[1:0]][21:16]] <= page[pg_i[1:0]][15:0];
            end
            pg_i <= pg_i + 3'h1;
          end
          pcnt <= pcnt + 32'h1;
          if (pcnt >= 32'(PROG_CYCLES - 1) && !fill_busy) begin
            state <= SEEC_IDLE;
            rdy_pend <= 1'b1;
          end
        end
        default: state <= SEEC_IDLE;
      endcase
    end
  end

  // Any page word inside the guarded area blocks the whole page
  always_comb begin
    guard_hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < pg_n && !guard_flag
          && page[i][21:16] >= guard_addr) begin
        guard_hit = 1'b1;
      end
    end
  end

  // Page store fills from the buffer, empties on return to idle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pg_n <= 3'h0;
    end else if (bout_valid && bout_ready) begin
      page[pg_n[1:0]] <= bout_data;
      pg_n <= pg_n + 3'h1;
    end else if (state == SEEC_IDLE) begin
      pg_n <= 3'h0;
    end
  end

  // Programming enable latch and guard register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prog_en <= 1'b0;
      gunlk <= 1'b0;
      guard_addr <= `SEEC_ADDR_ONES;
      guard_flag <= 1'b1;
      frozen <= 1'b0;
    end else if (state == SEEC_WAITEND && !sel_s[1]) begin
      gunlk <= 1'b0;
      if (cmd == SEEC_C_PLOCK) begin
        prog_en <= 1'b0;
      end else if (wp_ok) begin
        unique case (cmd)
          SEEC_C_PUNLK: prog_en <= 1'b1;
          SEEC_C_GUNLK: gunlk <= prog_en;
          SEEC_C_GSET: begin
            if (gunlk && !frozen) begin
              guard_addr <= addr;
              guard_flag <= 1'b0;
            end
          end
          SEEC_C_GRST: begin
            if (gunlk && !frozen) begin
              guard_addr <= `SEEC_ADDR_ONES;
              guard_flag <= 1'b1;
            end
          end
          SEEC_C_GFRZ: begin
            if (gunlk) begin
              frozen <= 1'b1;
            end
          end
          default: gunlk <= 1'b0;
        endcase
      end
    end
  end

  // Serial output: read bits on a clock rise, low while programming, high once ready
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sdo_o <= 1'b1;
      sdo_oe_n_o <= 1'b1;
      busy_o <= 1'b0;
      ready_hold <= 1'b0;
    end else begin
      busy_o <= (state == SEEC_PROG) || (state == SEEC_SKIP);
      if (!sel_s[1]) begin
        sdo_oe_n_o <= 1'b1;
        ready_hold <= 1'b0;
      end else if (state == SEEC_PROG) begin
        sdo_oe_n_o <= 1'b0;
        sdo_o <= 1'b0;
      end else if (sel_rise || rdy_pend) begin
        ready_hold <= rdy_pend;
        if (rdy_pend) begin
          sdo_oe_n_o <= 1'b0;
          sdo_o <= 1'b1;
        end
      end else if (rise && (state == SEEC_RDOUT || state == SEEC_GRDOUT)) begin
        sdo_oe_n_o <= 1'b0;
        sdo_o <= (bcnt == 5'h00) ? 1'b0 : sh[`SEEC_DATA_W-1];
      end else if (rise && state == SEEC_HDR) begin
        ready_hold <= 1'b0;
        sdo_oe_n_o <= 1'b1;
      end else if (ready_hold) begin
        sdo_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prog_en_o <= 1'b0;
      frozen_o <= 1'b0;
    end else begin
      prog_en_o <= prog_en;
      frozen_o <= frozen;
    end
  end
endmodule
`default_nettype wire

// ==== sim/seec_engine_properties.sv ====
/* Pin-level assertions for the command engine.
   Assumes a bind onto seec_engine with the same PROG_CYCLES. */
`timescale 1ns/1ps
`default_nettype none
module seec_props #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic sel_i, // Chip select
  input wire logic sclk_i, // Serial clock
  input wire logic wperm_i, // Write permission
  input wire logic sdo_o, // Data out
  input wire logic sdo_oe_n_o, // Data out drive, low active
  input wire logic busy_o, // Programming busy
  input wire logic prog_en_o, // Programming unlocked
  input wire logic frozen_o // Guard frozen
);
  logic [3:0] sel_age;
  logic [3:0] sel_hi;
  logic [3:0] rise_age;
  logic [3:0] quiet;
  int busy_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Cycles since select was last high
  always_ff @(posedge mclk_i) begin
    if (rst_i || sel_i) sel_age <= 4'h0;
    else if (sel_age != 4'hf) sel_age <= sel_age + 4'h1;
  end
  // Cycles that select has been high
  always_ff @(posedge mclk_i) begin
    if (rst_i || !sel_i) sel_hi <= 4'h0;
    else if (sel_hi != 4'hf) sel_hi <= sel_hi + 4'h1;
  end
  // Cycles since the last serial clock rise
  always_ff @(posedge mclk_i) begin
    if (rst_i || $rose(sclk_i)) rise_age <= 4'h0;
    else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
  end
  // Cycles since select or busy last moved
  always_ff @(posedge mclk_i) begin
    if (rst_i || $changed(sel_i) || $changed(busy_o)) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i || !busy_o) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  a_reset_values: assert property (
    $fell(rst_i) |-> sdo_o && sdo_oe_n_o && !busy_o && !prog_en_o
      && !frozen_o) else $error("outputs wrong after reset");
  a_sdo_on_rise: assert property (
    quiet > 4'h7 && sel_i && $changed(sdo_o) |-> rise_age < 4'h7)
    else $error("data out moved without a clock rise");
  a_frozen_sticky: assert property (
    frozen_o |=> frozen_o) else $error("frozen bit cleared");
  a_freeze_unlocked: assert property (
    $rose(frozen_o) |-> prog_en_o) else $error("freeze while locked");
  a_unlock_perm: assert property (
    $rose(prog_en_o) |-> wperm_i) else $error("unlock without permission");
  a_unlock_framed: assert property (
    $changed(prog_en_o) |-> sel_age < 4'h8)
    else $error("unlock state moved outside an instruction");
  a_busy_start: assert property (
    $rose(busy_o) |-> !sel_i && sel_age < 4'h8)
    else $error("busy not started by select fall");
  a_busy_bound: assert property (
    busy_o |-> busy_cnt <= PROG_CYCLES + 8) else $error("busy too long");
  a_busy_low_out: assert property (
    busy_o && sel_hi > 4'h6 |-> !sdo_o) else $error("busy not shown low");
  a_release_out: assert property (
    sel_age > 4'hb |-> sdo_oe_n_o) else $error("data out not released");
endmodule
`default_nettype wire

// ==== sim/seec_host_model.sv ====
/* Host model framing instructions on the serial pins.
   Assumes the bench clock; pins move on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module seec_host_model (
  input wire logic mclk_i, // Bench clock
  input wire logic sdo_i, // Device data out
  output logic sel_o, // Chip select
  output logic sclk_o, // Serial clock, still between frames
  output logic sdi_o, // Serial data in
  output logic wperm_o, // Write permission
  output logic gacc_o // Guard access
);
  initial begin
    sel_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    wperm_o = 1'b0;
    gacc_o = 1'b0;
  end
  // Sends n bits MSB first at 200 ns; rd gathers data out per rise
  task automatic send(input logic ga, input logic wp,
      input logic [63:0] bits, input int n, output logic [63:0] rd);
    int i;
    rd = '0;
    repeat (10) @(negedge mclk_i);
    gacc_o = ga;
    wperm_o = wp;
    repeat (4) @(negedge mclk_i);
    sel_o = 1'b1;
    for (i = n - 1; i >= 0; i--) begin
      sdi_o = bits[i];
      repeat (4) @(negedge mclk_i);
      rd = {rd[62:0], sdo_i};
      sclk_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge mclk_i);
    rd = {rd[62:0], sdo_i};
    sel_o = 1'b0;
    sdi_o = ~sdi_o;
  endtask
  // Raises select without clocking and samples the status level
  task automatic poll(output logic s);
    repeat (10) @(negedge mclk_i);
    sel_o = 1'b1;
    repeat (8) @(negedge mclk_i);
    s = sdo_i;
    sel_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== sim/seec_engine_tb.sv ====
/* Self-checking bench for the command engine.
   Assumes the host model and the checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module seec_engine_tb;
  localparam int PROG_CYCLES = 80;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sel, sclk, sdi, wperm, gacc, sdo, sdo_oe_n, busy, prog_en, frozen;
  logic [63:0] rd;
  logic s;
  int miscompares = 0;
  int comparisons = 0;
  seec_engine #(.PROG_CYCLES(PROG_CYCLES)) dut (
    .mclk_i(mclk), .rst_i(rst), .sel_i(sel), .sclk_i(sclk),
    .sdi_i(sdi), .wperm_i(wperm), .gacc_i(gacc), .sdo_o(sdo),
    .sdo_oe_n_o(sdo_oe_n), .busy_o(busy), .prog_en_o(prog_en),
    .frozen_o(frozen));
  seec_host_model host (
    .mclk_i(mclk), .sdo_i(sdo), .sel_o(sel), .sclk_o(sclk), .sdi_o(sdi),
    .wperm_o(wperm), .gacc_o(gacc));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [16:0] exp,
      input logic [16:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    int i;
    repeat (8) @(negedge mclk);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge mclk);
  endtask
  task automatic cmd(input logic ga, input logic wp, input logic [1:0] op,
      input logic [5:0] a, input logic [15:0] d, input int nd);
    host.send(ga, wp, {39'h0, 1'b1, op, a, d} >> (16 - nd), 9 + nd, rd);
    settle();
  endtask
  task automatic read_chk(input logic [5:0] a, input logic [15:0] d);
    host.send(1'b0, 1'b0, {38'h0, 1'b1, 2'h2, a, 17'h0}, 26, rd);
    check("read word", {1'b0, d}, rd[16:0]);
  endtask
  task automatic guard_chk(input logic [6:0] v);
    host.send(1'b1, 1'b0, {47'h0, 1'b1, 2'h2, 6'h00, 8'h0}, 17, rd);
    check("guard", {10'h0, v}, {9'h0, rd[7:0]});
  endtask
  task automatic gul();
    cmd(1'b1, 1'b1, 2'h0, 6'h30, 16'h0, 0);
  endtask
  task automatic t_write();
    check("reset pins", 17'h18, {12'h0, sdo, sdo_oe_n, busy, prog_en,
      frozen});
    cmd(1'b0, 1'b1, 2'h0, 6'h30, 16'h0, 0);
    check("unlock", 17'h1, {16'h0, prog_en});
    cmd(1'b0, 1'b1, 2'h1, 6'h03, 16'ha5c3, 16);
    read_chk(6'h03, 16'ha5c3);
    cmd(1'b0, 1'b0, 2'h1, 6'h03, 16'h0000, 16);
    read_chk(6'h03, 16'ha5c3);
    cmd(1'b0, 1'b1, 2'h0, 6'h00, 16'h0, 0);
    check("lock", 17'h0, {16'h0, prog_en});
    cmd(1'b0, 1'b1, 2'h1, 6'h03, 16'h1111, 16);
    read_chk(6'h03, 16'ha5c3);
    $display("test write done");
  endtask
  task automatic t_seq_page();
    cmd(1'b0, 1'b1, 2'h0, 6'h30, 16'h0, 0);
    cmd(1'b0, 1'b1, 2'h1, 6'h04, 16'h5a3c, 16);
    host.send(1'b0, 1'b0, 64'({1'b1, 2'h2, 6'h03}) << 33, 42, rd);
    check("first", {1'b0, 16'ha5c3}, rd[32:16]);
    check("next", {1'b0, 16'h5a3c}, {1'b0, rd[15:0]});
    host.send(1'b0, 1'b1, {7'h0, 1'b1, 2'h3, 6'h0f, 16'h1111, 16'h2222,
      16'h3333}, 57, rd);
    settle();
    read_chk(6'h0f, 16'h1111);
    read_chk(6'h0c, 16'h2222);
    read_chk(6'h0d, 16'h3333);
    $display("test sequence and page done");
  endtask
  task automatic t_busy();
    host.send(1'b0, 1'b1, {39'h0, 1'b1, 2'h1, 6'h05, 16'h0505}, 25, rd);
    host.poll(s);
    check("busy level", 17'h2, {15'h0, busy, s});
    settle();
    host.poll(s);
    check("ready level", 17'h1, {16'h0, s});
    read_chk(6'h05, 16'h0505);
    $display("test busy done");
  endtask
  task automatic t_guard();
    cmd(1'b0, 1'b1, 2'h1, 6'h21, 16'hbeef, 16);
    cmd(1'b0, 1'b1, 2'h1, 6'h22, 16'hcafe, 16);
    gul();
    cmd(1'b1, 1'b1, 2'h1, 6'h22, 16'h0, 0);
    guard_chk({6'h22, 1'b0});
    cmd(1'b0, 1'b1, 2'h1, 6'h22, 16'h0000, 16);
    read_chk(6'h22, 16'hcafe);
    host.send(1'b0, 1'b1, {7'h0, 1'b1, 2'h3, 6'h20, 16'h1111, 16'h2222,
      16'h3333}, 57, rd);
    settle();
    read_chk(6'h21, 16'hbeef);
    cmd(1'b0, 1'b1, 2'h1, 6'h21, 16'h2121, 16);
    read_chk(6'h21, 16'h2121);
    cmd(1'b0, 1'b1, 2'h0, 6'h10, 16'h0f0f, 16);
    read_chk(6'h21, 16'h2121);
    gul();
    cmd(1'b1, 1'b1, 2'h3, 6'h3f, 16'h0, 0);
    guard_chk({6'h3f, 1'b1});
    cmd(1'b0, 1'b1, 2'h0, 6'h10, 16'h0f0f, 16);
    read_chk(6'h22, 16'h0f0f);
    gul();
    cmd(1'b1, 1'b1, 2'h0, 6'h00, 16'h0, 0);
    check("frozen", 17'h1, {16'h0, frozen});
    gul();
    cmd(1'b1, 1'b1, 2'h1, 6'h10, 16'h0, 0);
    guard_chk({6'h3f, 1'b1});
    cmd(1'b0, 1'b1, 2'h0, 6'h00, 16'h0, 0);
    $display("test guard done");
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    t_write();
    t_seq_page();
    t_busy();
    t_guard();
    print_verdict();
  end
  // Roughly nine times the expected run length
  initial begin
    repeat (80000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
endmodule
bind seec_engine seec_props #(.PROG_CYCLES(PROG_CYCLES)) props (
  .mclk_i(mclk_i), .rst_i(rst_i), .sel_i(sel_i), .sclk_i(sclk_i),
  .wperm_i(wperm_i), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
  .busy_o(busy_o), .prog_en_o(prog_en_o), .frozen_o(frozen_o));
`default_nettype wire
